/* adc_analog_model.sv */
// Analog input pins and sample-and-hold stage facing the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
  input wire logic CLK_IN,
  input wire logic [69:0] LEVELS_IN,
  input wire logic [2:0] CHANNEL_IN,
  input wire logic SAMPLE_IN,
  input wire logic [9:0] TRIAL_IN,
  output logic COMPARE_OUT
);
  logic [9:0] held = 10'h000;

  // ---------------------------------------------------------------------------
  // Holding capacitor
  // ---------------------------------------------------------------------------
  // Follows the channel only while connected and keeps its charge otherwise
  always @(posedge CLK_IN) begin
    if (SAMPLE_IN === 1'b1 && CHANNEL_IN < 3'h7) begin
      held <= LEVELS_IN[CHANNEL_IN * 10 +: 10];
    end
  end

  assign COMPARE_OUT = (held >= TRIAL_IN);
endmodule
`default_nettype wire

/* adc_conversion_sequencer.sv */
// Successive-approximation converter sequencer with APB register access
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.svh"

module adc_conversion_sequencer (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic COMPARE_IN,
  input wire logic [6:0] PORT_PINS_IN,
  output logic [9:0] TRIAL_OUT,
  output logic [2:0] CHANNEL_OUT,
  output logic [1:0] VREF_SELECT_OUT,
  output logic SAMPLE_CONNECT_OUT,
  output logic CONVERTER_POWER_OUT,
  output logic CONVERTING_OUT,
  output logic IRQ_OUT
);

  adc_seq_pkg::seq_regs_t s;
  adc_seq_pkg::seq_regs_t next_s;
  logic setup;
  logic wr;
  logic mapped;
  logic tick;
  logic [9:0] tad_len;
  logic [9:0] tv;
  logic [31:0] rd;
  logic go_req;

  // ----------------------------------------------------------------------------
  // Bit period length in system clocks
  // ----------------------------------------------------------------------------
  always_comb begin
    case (s.conv_clock_select)
      2'b00: tad_len = s.clock_halve_select ? 10'h004 : 10'h002;
      2'b01: tad_len = s.clock_halve_select ? 10'h010 : 10'h008;
      2'b10: tad_len = s.clock_halve_select ? 10'h040 : 10'h020;
      default: tad_len = 10'(`RC_TAD_CYCLES);
    endcase
  end

  assign tick = (s.tad_cnt >= tad_len - 10'h001);

  // ----------------------------------------------------------------------------
  // Bus decode and read mux
  // ----------------------------------------------------------------------------
  assign setup = PSEL_IN && !PENABLE_IN;
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0];
  assign mapped = (PADDR_IN == `OFS_CONTROL_0) || (PADDR_IN == `OFS_CONTROL_1) ||
                  (PADDR_IN == `OFS_PIN_SELECT) || (PADDR_IN == `OFS_RESULT_HIGH) ||
                  (PADDR_IN == `OFS_RESULT_LOW) || (PADDR_IN == `OFS_IRQ_CONTROL) ||
                  (PADDR_IN == `OFS_PORT_READ);

  always_comb begin
    rd = 32'h0000_0000;
    case (PADDR_IN)
      `OFS_CONTROL_0: rd[7:0] = {s.conv_clock_select, s.channel_select, s.go, 1'b0,
                                 s.converter_power_on};
      `OFS_CONTROL_1: rd[7:0] = {s.result_format_select, s.clock_halve_select,
                                 s.vref_select, 4'h0};
      `OFS_PIN_SELECT: rd[6:0] = s.analog_pin_select;
      `OFS_RESULT_HIGH: rd[7:0] = s.result_format_select ?
                                  {6'h00, s.result_high_byte[1:0]} : s.result_high_byte;
      `OFS_RESULT_LOW: rd[7:0] = s.result_format_select ?
                                 s.result_low_byte : {s.result_low_byte[7:6], 6'h00};
      `OFS_IRQ_CONTROL: rd[3:0] = {s.global_irq_enable, s.peripheral_irq_enable,
                                   s.conversion_irq_enable, s.conversion_complete_flag};
      `OFS_PORT_READ: rd[6:0] = s.pin_s2 & ~s.analog_pin_select;
      default: rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    tv = s.trial;
    next_s.cmp_s1 = COMPARE_IN;
    next_s.cmp_s2 = s.cmp_s1;
    next_s.pin_s1 = PORT_PINS_IN;
    next_s.pin_s2 = s.pin_s1;
    if (setup) begin
      next_s.prdata = rd;
    end
    next_s.tad_cnt = tick ? 10'h000 : 10'(s.tad_cnt + 10'h001);

    // Software writes
    if (wr) begin
      case (PADDR_IN)
        `OFS_CONTROL_0: begin
          next_s.conv_clock_select = PWDATA_IN[`POS_CLOCK_SELECT +: 2];
          next_s.channel_select = PWDATA_IN[`POS_CHANNEL +: 3];
          next_s.converter_power_on = PWDATA_IN[`POS_POWER];
          if (!PWDATA_IN[`POS_GO]) begin
            next_s.go = 1'b0;
          end else if (s.converter_power_on && s.st == adc_seq_pkg::ST_ACQ) begin
            next_s.go = 1'b1;
          end
        end
        `OFS_CONTROL_1: begin
          next_s.result_format_select = PWDATA_IN[`POS_FORMAT];
          next_s.clock_halve_select = PWDATA_IN[`POS_HALVE];
          next_s.vref_select = PWDATA_IN[`POS_VREF +: 2];
        end
        `OFS_PIN_SELECT: next_s.analog_pin_select = PWDATA_IN[6:0];
        `OFS_RESULT_HIGH: next_s.result_high_byte = PWDATA_IN[7:0];
        `OFS_RESULT_LOW: next_s.result_low_byte = PWDATA_IN[7:0];
        `OFS_IRQ_CONTROL: begin
          next_s.conversion_complete_flag = PWDATA_IN[`POS_FLAG];
          next_s.conversion_irq_enable = PWDATA_IN[`POS_IRQ_EN];
          next_s.peripheral_irq_enable = PWDATA_IN[`POS_PERIPH_EN];
          next_s.global_irq_enable = PWDATA_IN[`POS_GLOBAL_EN];
        end
        default: next_s.go = next_s.go;
      endcase
    end

    // Go as software left it, before completion clears it
    go_req = next_s.go;

    // Sequencer; direction and pin mode never gate a conversion
    case (s.st)
      adc_seq_pkg::ST_OFF: begin
        next_s.go = 1'b0;
        if (next_s.converter_power_on) begin
          next_s.st = adc_seq_pkg::ST_ACQ;
        end
      end
      adc_seq_pkg::ST_ACQ: begin
        if (next_s.go) begin
          next_s.st = adc_seq_pkg::ST_FIRST;
        end
      end
      adc_seq_pkg::ST_FIRST: begin
        if (!next_s.go) begin
          next_s.st = adc_seq_pkg::ST_POST;
          next_s.post_left = 2'(`POST_TADS);
          next_s.tad_cnt = 10'h000;
        end else if (tick) begin
          next_s.st = adc_seq_pkg::ST_CONV;
          next_s.bit_idx = 4'(`CONV_BITS - 1);
          next_s.trial = 10'h200;
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (!next_s.go) begin
          next_s.st = adc_seq_pkg::ST_POST;
          next_s.post_left = 2'(`POST_TADS);
          next_s.tad_cnt = 10'h000;
        end else if (tick) begin
          if (!s.cmp_s2) begin
            tv[s.bit_idx] = 1'b0;
          end
          if (s.bit_idx != 4'h0) begin
            tv[s.bit_idx - 4'h1] = 1'b1;
            next_s.bit_idx = s.bit_idx - 4'h1;
          end else begin
            next_s.go = 1'b0;
            next_s.conversion_complete_flag = 1'b1;
            next_s.st = adc_seq_pkg::ST_POST;
            next_s.post_left = 2'(`POST_TADS);
            if (s.result_format_select) begin
              next_s.result_high_byte = {6'h00, tv[9:8]};
              next_s.result_low_byte = tv[7:0];
            end else begin
              next_s.result_high_byte = tv[9:2];
              next_s.result_low_byte = {tv[1:0], 6'h00};
            end
          end
          next_s.trial = tv;
        end
      end
      adc_seq_pkg::ST_POST: begin
        // Capacitor stays isolated and keeps its charge
        if (tick) begin
          next_s.post_left = s.post_left - 2'h1;
          if (s.post_left == 2'h1) begin
            next_s.st = adc_seq_pkg::ST_ACQ;
          end
        end
      end
      default: next_s.st = adc_seq_pkg::ST_OFF;
    endcase

    if (!next_s.converter_power_on) begin
      next_s.st = adc_seq_pkg::ST_OFF;
      next_s.go = 1'b0;
      next_s.tad_cnt = 10'h000;
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      s <= '0;
      s.st <= adc_seq_pkg::ST_OFF;
      s.analog_pin_select <= `RST_PIN_SELECT;
      s.result_high_byte <= `RST_BYTE;
      s.result_low_byte <= `RST_BYTE;
    end else if (CLK_EN_IN) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign PRDATA_OUT = s.prdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
  assign TRIAL_OUT = s.trial;
  assign CHANNEL_OUT = s.channel_select;
  assign VREF_SELECT_OUT = s.vref_select;
  assign SAMPLE_CONNECT_OUT = (s.st == adc_seq_pkg::ST_ACQ);
  assign CONVERTER_POWER_OUT = s.converter_power_on;
  assign CONVERTING_OUT = (s.st == adc_seq_pkg::ST_CONV);
  assign IRQ_OUT = s.conversion_complete_flag && s.conversion_irq_enable &&
                   s.peripheral_irq_enable && s.global_irq_enable;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  localparam int FIRST_MAX = `RC_TAD_CYCLES;
  logic done_now;
  assign done_now = CLK_EN_IN && next_s.converter_power_on &&
                    s.st == adc_seq_pkg::ST_CONV && go_req && tick && s.bit_idx == 4'h0;

  chk_done_flag: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    done_now |=> s.conversion_complete_flag && !s.go && s.st == adc_seq_pkg::ST_POST)
    else $error("completion did not set flag and clear go");
  chk_post_isolated: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    s.st == adc_seq_pkg::ST_POST |-> !SAMPLE_CONNECT_OUT)
    else $error("capacitor connected during post delay");
  chk_post_two_tad: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (s.st == adc_seq_pkg::ST_ACQ && $past(s.st) == adc_seq_pkg::ST_POST)
    |-> $past(s.post_left) == 2'h1 && $past(tick))
    else $error("acquisition resumed before two bit periods");
  chk_ten_bits: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    $rose(CONVERTING_OUT) |-> s.bit_idx == 4'h9 && s.trial == 10'h200)
    else $error("conversion did not start at top bit");
  chk_abort_keeps: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (CLK_EN_IN && s.st == adc_seq_pkg::ST_CONV && !go_req && next_s.converter_power_on)
    |=> $stable(s.result_high_byte) && $stable(s.result_low_byte) &&
        s.st == adc_seq_pkg::ST_POST)
    else $error("abort changed result pair");
  chk_right_mask: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (setup && PADDR_IN == `OFS_RESULT_HIGH && s.result_format_select && CLK_EN_IN)
    |=> PRDATA_OUT[7:2] == 6'h00)
    else $error("right justified high byte not masked");
  chk_port_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (setup && PADDR_IN == `OFS_PORT_READ && CLK_EN_IN)
    |=> (PRDATA_OUT[6:0] & $past(s.analog_pin_select)) == 7'h00)
    else $error("analog pin read as one");
  chk_irq_gate: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    IRQ_OUT |-> s.conversion_complete_flag && s.global_irq_enable)
    else $error("interrupt without flag and enable");
  chk_first_seg: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    $rose(s.st == adc_seq_pkg::ST_FIRST) |-> ##[1:FIRST_MAX] s.st != adc_seq_pkg::ST_FIRST)
    else $error("first segment too long");
  chk_power_off: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (CLK_EN_IN && !next_s.converter_power_on) |=> s.st == adc_seq_pkg::ST_OFF && !s.go)
    else $error("converter not off after power clear");

  cov_complete: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN) done_now);
  cov_abort: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    s.st == adc_seq_pkg::ST_CONV ##1 s.st == adc_seq_pkg::ST_POST && !s.conversion_complete_flag);
  cov_rc_clock: cover property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    done_now && s.conv_clock_select == 2'b11);

endmodule
`default_nettype wire

/* adc_conversion_sequencer_bench.sv */
// Self-checking testbench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_bench;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, cmp, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, h0, l0;
  logic [3:0] pstrb;
  logic [6:0] pins;
  logic [69:0] levels;
  logic [9:0] trial;
  logic [2:0] chan;
  logic sconn, power, conv, irq;
  logic [1:0] vref;
  int mismatches, samples_checked, conv_cyc, post_cyc, n;
  bit post_on, was_conv;

  adc_conversion_sequencer i_dut (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .CLK_EN_IN(1'b1), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .COMPARE_IN(cmp), .PORT_PINS_IN(pins), .TRIAL_OUT(trial), .CHANNEL_OUT(chan),
    .VREF_SELECT_OUT(vref), .SAMPLE_CONNECT_OUT(sconn), .CONVERTER_POWER_OUT(power),
    .CONVERTING_OUT(conv), .IRQ_OUT(irq));

  adc_analog_model i_analog (.CLK_IN(clk), .LEVELS_IN(levels), .CHANNEL_IN(chan),
    .SAMPLE_IN(sconn), .TRIAL_IN(trial), .COMPARE_OUT(cmp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Phase counters
  // ---------------------------------------------------------------------------
  // Sampled on the falling edge, clear of the design's own updates
  always @(negedge clk) begin
    if (conv === 1'b1) conv_cyc++;
    if (was_conv && conv !== 1'b1) post_on = 1'b1;
    if (sconn === 1'b1) post_on = 1'b0;
    if (post_on) post_cyc++;
    was_conv = (conv === 1'b1);
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic lost(input bit hit);
    if (hit) begin
      mismatches++;
      $display("BAD t=%0t wait limit reached", $time);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    lost(k >= 50);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, {24'h0, e});
  endtask

  task automatic wait_acq;
    int k;
    k = 0;
    while (sconn !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    lost(k >= 2000);
    repeat (20) @(posedge clk);
  endtask

  // Code i: halve bit is i[0], clock select i[2:1]; 6 selects the RC clock
  task automatic convert(input int i, input bit res);
    logic [2:0] ch;
    logic [1:0] sel;
    logic [9:0] lv;
    logic f;
    int t;
    logic [1:0] v;
    ch = 3'($urandom_range(6));
    f = 1'($urandom_range(1));
    sel = (i == 6) ? 2'b11 : 2'(i >> 1);
    t = (i == 6) ? 400 : (2 << i);
    lv = 10'($urandom);
    levels[ch * 10 +: 10] <= lv;
    pins <= 7'($urandom);
    wr(12'h008, 8'($urandom));
    v = 2'($urandom);
    wr(12'h004, {f, 1'(i), v, 4'h0});
    chk({30'h0, vref}, {30'h0, v});
    wr(12'h000, {sel, ch, 3'b001});
    wait_acq;
    conv_cyc = 0;
    post_cyc = 0;
    wr(12'h000, {sel, ch, 3'b101});
    n = 0;
    do begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
    end while (r[2] === 1'b1 && n < 3000);
    lost(n >= 3000);
    chk(32'(conv_cyc), 32'(10 * t));
    chk({29'h0, chan}, {29'h0, ch});
    if (res) begin
      rdc(12'h00C, f ? {6'h0, lv[9:8]} : lv[9:2]);
      rdc(12'h010, f ? lv[7:0] : {lv[1:0], 6'h0});
    end
    wait_acq;
    chk(32'(post_cyc), 32'(2 * t));
    $display("conversion test %0d done", i);
  endtask

  // ---------------------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    $display("BAD t=%0t timeout", $time);
    test_done;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] h, l, s;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pins = 7'h00;
    levels = 70'h0;
    r = $urandom(32'h1310);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(12'h008, 8'h7F);
    rdc(12'h000, 8'h00);
    apb(1'b0, 12'h01C, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset test done");
    wr(12'h000, 8'h04);
    rdc(12'h000, 8'h00);
    chk({31'h0, power}, 32'h0);
    wr(12'h000, 8'h05);
    rdc(12'h000, 8'h01);
    chk({31'h0, power}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      convert(i, i > 0);
    end
    wr(12'h014, 8'h0E);
    // Divider codes run past their frequency limits to keep runs short;
    // the RC code alone gives a legal 4 us bit period
    convert(6, 1'b1);
    rdc(12'h014, 8'h0F);
    chk({31'h0, irq}, 32'h1);
    wr(12'h014, 8'h07);
    chk({31'h0, irq}, 32'h0);
    wr(12'h014, 8'h0B);
    chk({31'h0, irq}, 32'h0);
    wr(12'h014, 8'h0E);
    chk({31'h0, irq}, 32'h0);
    $display("interrupt test done");
    wr(12'h004, 8'h00);
    wr(12'h000, 8'h51);
    wait_acq;
    apb(1'b0, 12'h00C, 32'h0);
    h0 = r;
    apb(1'b0, 12'h010, 32'h0);
    l0 = r;
    wr(12'h014, 8'h00);
    wr(12'h000, 8'h55);
    n = 0;
    while (conv !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    lost(n >= 100);
    repeat (5) @(posedge clk);
    post_cyc = 0;
    wr(12'h000, 8'h51);
    wait_acq;
    chk(32'(post_cyc), 32'd16);
    apb(1'b0, 12'h00C, 32'h0);
    chk(r, h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(r, l0);
    rdc(12'h014, 8'h00);
    $display("abort test done");
    wr(12'h000, 8'h00);
    for (int f = 0; f < 2; f++) begin
      h = 8'($urandom);
      l = 8'($urandom);
      wr(12'h004, {1'(f), 7'h0});
      wr(12'h00C, h);
      wr(12'h010, l);
      rdc(12'h00C, f ? {6'h0, h[1:0]} : h);
      rdc(12'h010, f ? l : {l[7:6], 6'h0});
    end
    for (int k = 0; k < 4; k++) begin
      s = 8'($urandom) & 8'h7F;
      wr(12'h008, s);
      pins <= 7'($urandom);
      repeat (4) @(posedge clk);
      rdc(12'h018, {1'b0, pins & ~s[6:0]});
    end
    $display("storage and port test done");
    test_done;
  end
endmodule
`default_nettype wire

/* adc_seq_consts.svh */
// Register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL_0 12'h000
`define OFS_CONTROL_1 12'h004
`define OFS_PIN_SELECT 12'h008
`define OFS_RESULT_HIGH 12'h00C
`define OFS_RESULT_LOW 12'h010
`define OFS_IRQ_CONTROL 12'h014
`define OFS_PORT_READ 12'h018

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define POS_CLOCK_SELECT 6
`define POS_CHANNEL 3
`define POS_GO 2
`define POS_POWER 0
`define POS_FORMAT 7
`define POS_HALVE 6
`define POS_VREF 4
`define POS_FLAG 0
`define POS_IRQ_EN 1
`define POS_PERIPH_EN 2
`define POS_GLOBAL_EN 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_PIN_SELECT 7'h7F
`define RST_BYTE 8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define RC_PERIOD_NS 4000
`define RC_TAD_CYCLES (`RC_PERIOD_NS / `CLK_PERIOD_NS)
`define POST_TADS 2
`define CONV_BITS 10
`define TAD_PER_8BIT 9

`endif

/* adc_seq_pkg.sv */
// Types shared by the converter sequencer
package adc_seq_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ACQ,
    ST_FIRST,
    ST_CONV,
    ST_POST
  } seq_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [1:0] conv_clock_select;
    logic [2:0] channel_select;
    logic go;
    logic converter_power_on;
    logic result_format_select;
    logic clock_halve_select;
    logic [1:0] vref_select;
    logic [6:0] analog_pin_select;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic conversion_complete_flag;
    logic conversion_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic [9:0] tad_cnt;
    logic [3:0] bit_idx;
    logic [9:0] trial;
    logic [1:0] post_left;
    logic [31:0] prdata;
    logic cmp_s1;
    logic cmp_s2;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
  } seq_regs_t;

endpackage
